// file: astq_top.sv
// Auto test sequencer: program store, step timing, judging and connector pins.
//
// Summary of operation
// - Ten programs, ten steps, hundred records.
// - Only selected steps run.
// - Hold-flagged step pauses before continuing.
// - Short-flagged step applies short instead.
// - Load on for loading seconds.
// - Load off for unloading seconds.
// - Measure at pass/fail delay, or at load end if sooner.
// - Stop at completion or first failure.
// - Link of 1 to 10 chains to that program.
// - Record index is ten(n-1) plus k.
// - Record holds mode, setpoint, limits.
// - Start input begins selected program.
// - Pause input suspends running test.
// - Next/previous inputs move one step.
// - Failure output on judged failure.
// - Pass output on passing result.
// - Indicator while load or short is on.
// - Warning tone output on alerts.
// - Analog mode: prev selects CC, next CV.
// - Recalled program shown stopped until run.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module astq_top
  import astq_pkg::*;
#(
  parameter int SEC_CYC = SEC_CYCLES,
  parameter int TONE_CYC = TONE_CYCLES,
  parameter int PULSE_CYC = MIN_PULSE_CYC,
  parameter bit IN_ACT_LOW = IN_ACT_LOW_DEF,
  parameter bit OUT_ACT_LOW = OUT_ACT_LOW_DEF
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Connector inputs.
  input wire logic pin_prev_step,
  input wire logic pin_start,
  input wire logic pin_next_step,
  input wire logic pin_pause,
  // Connector outputs.
  output logic pin_input_on,
  output logic pin_fail,
  output logic pin_pass,
  output logic pin_tone,
  // Load regulation side.
  input wire logic [15:0] meas_value,
  output logic load_on,
  output logic short_on,
  output logic [1:0] step_mode,
  output logic [15:0] step_setpt,
  output logic constant_current_op,
  output logic constant_voltage_op
);

  localparam int SCW = $clog2(SEC_CYC);
  localparam int TCW = $clog2(TONE_CYC + 1);

  // Refuse time bases the counters cannot serve.
  if (SEC_CYC < 2 || TONE_CYC < 1)
  begin : g_bad
    $error("Second and tone counts must be positive.");
  end

  // Program and step storage, kept across reset like the device's store.
  astq_prog_t prog_mem [NUM_PROG];
  astq_rec_t rec_mem [NUM_REC];

  // Bus side state.
  logic acc; // Access phase not yet answered.
  logic [11:0] poff; // Offset into the program window.
  logic [11:0] roff; // Offset into the record window.
  logic prog_hit; // Address falls in the program window.
  logic rec_hit; // Address falls in the record window.
  logic [3:0] pidx; // Program addressed by the bus.
  logic [6:0] ridx; // Record addressed by the bus.
  logic [31:0] rd_d; // Read data for the addressed word.
  logic err_d; // Unmapped address.
  logic [3:0] prog_sel_q; // Program recalled for the next run.
  logic analog_q; // External analog control mode.
  astq_cmd_t sw_cmd_q; // Software command pulses.
  logic sw_stop_q; // Software stop pulse.

  // Sequencer state.
  astq_state_t state_q;
  logic [3:0] prog_q; // Running program, 1 to 10.
  logic [3:0] step_q; // Current step slot, 0 to 9.
  logic first_q; // Next seek starts from the first slot.
  logic paused_q; // Run suspended.
  logic sampled_q; // Current step already judged.
  logic failed_q; // Some step failed in this run.
  logic passed_q; // Run completed with no failure.
  logic [SCW-1:0] cyc_q; // Cycles within the current second.
  logic [15:0] sec_q; // Whole seconds in the current phase.
  logic [TCW-1:0] tone_q; // Remaining tone cycles.
  logic alert; // Event that sounds the tone.
  logic [1:0] op_mode_q; // Mode picked in analog control.

  astq_cmd_t pin_cmd; // Qualified connector events.
  astq_cmd_t cmd; // Merged commands.
  astq_prog_t cur_p; // Frame of the running program.
  astq_rec_t cur_r; // Record of the current step.
  logic [6:0] cur_ri; // Record index of the current step.
  logic [4:0] seek_r; // Forward search result.
  logic [4:0] back_r; // Backward search result.
  logic judge; // Judge the measurement this cycle.
  logic bad; // Measurement outside the limits.
  logic tick; // Last cycle of a second.

  // Find the nearest selected slot after or before a position; bit 4 set means none.
  function automatic logic [4:0] find_sel(input logic [9:0] m, input int from,
                                          input bit fwd);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < NUM_STEP; i++)
    begin
      if (m[i] && (fwd ? (i > from && r[4]) : (i < from)))
        r = {1'b0, 4'(i)};
    end
    return r;
  endfunction

  // One conditioner per connector input.
  for (genvar g = 0; g < 4; g++)
  begin : g_pin
    logic raw;
    assign raw = (g == 0) ? pin_start : (g == 1) ? pin_pause :
                 (g == 2) ? pin_next_step : pin_prev_step;
    astq_pin_cond #(
      .ACT_LOW(IN_ACT_LOW),
      .MIN_CYC(PULSE_CYC)
    ) u_cond (
      .pclk(pclk),
      .presetn(presetn),
      .pin(raw),
      .fire(pin_cmd[3 - g])
    );
  end

  // Connector and software commands act alike.
  assign cmd = pin_cmd | sw_cmd_q;

  // Bus address decode.
  assign acc = psel && penable && !pready;
  assign poff = paddr - PROG_BASE;
  assign roff = paddr - REC_BASE;
  assign prog_hit = (paddr >= PROG_BASE) && (paddr < PROG_END);
  assign rec_hit = (paddr >= REC_BASE) && (paddr < REC_END);
  assign pidx = poff[6:3];
  assign ridx = roff[10:4];

  // Read mux; unmapped addresses answer zero with an error.
  always_comb
  begin
    rd_d = 32'h0000_0000;
    err_d = 1'b0;
    if (paddr == CTRL_OFF)
      rd_d = {20'h0_0000, prog_sel_q, 1'b0, analog_q, 6'h00};
    else if (paddr == STAT_OFF)
      rd_d = {12'h000, op_mode_q, load_on, short_on, step_q, prog_q, 2'h0,
              passed_q, failed_q, paused_q, 1'b0, state_q};
    else if (prog_hit && !paddr[2])
      rd_d = {2'h0, prog_mem[pidx].shrt, prog_mem[pidx].hold, prog_mem[pidx].active};
    else if (prog_hit)
      rd_d = {27'h000_0000, prog_mem[pidx].stop_fail, prog_mem[pidx].chain};
    else if (rec_hit)
    begin
      unique case (paddr[3:2])
        2'h0: rd_d = {14'h0000, rec_mem[ridx].mode, rec_mem[ridx].setpt};
        2'h1: rd_d = {rec_mem[ridx].hi, rec_mem[ridx].lo};
        2'h2: rd_d = {rec_mem[ridx].off_s, rec_mem[ridx].on_s};
        2'h3: rd_d = {16'h0000, rec_mem[ridx].pf_s};
      endcase
    end
    else
      err_d = 1'b1;
  end

  // Answer one cycle after the access phase opens.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= acc;
      pslverr <= acc && err_d;
      if (acc && !pwrite)
        prdata <= rd_d;
    end
  end

  // Control register: program recall, analog mode and command pulses.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prog_sel_q <= PROG_SEL_RST;
      analog_q <= 1'b0;
      sw_cmd_q <= '0;
      sw_stop_q <= 1'b0;
    end
    else
    begin
      sw_cmd_q <= '0;
      sw_stop_q <= 1'b0;
      if (acc && pwrite && paddr == CTRL_OFF)
      begin
        // Out-of-range program numbers leave the recall unchanged.
        if (pwdata[CTRL_RECALL] && pwdata[CTRL_PROG_LSB +: 4] >= 4'h1 &&
            pwdata[CTRL_PROG_LSB +: 4] <= 4'ha)
          prog_sel_q <= pwdata[CTRL_PROG_LSB +: 4];
        analog_q <= pwdata[CTRL_ANALOG];
        sw_cmd_q <= {pwdata[CTRL_START], pwdata[CTRL_PAUSE],
                     pwdata[CTRL_NEXT], pwdata[CTRL_PREV]};
        sw_stop_q <= pwdata[CTRL_STOP];
      end
    end
  end

  // Storage writes, word by word.
  always_ff @(posedge pclk)
  begin
    if (acc && pwrite && prog_hit && !paddr[2])
    begin
      prog_mem[pidx].active <= pwdata[9:0];
      prog_mem[pidx].hold <= pwdata[19:10];
      prog_mem[pidx].shrt <= pwdata[29:20];
    end
    else if (acc && pwrite && prog_hit)
    begin
      prog_mem[pidx].chain <= pwdata[3:0];
      prog_mem[pidx].stop_fail <= pwdata[4];
    end
    if (acc && pwrite && rec_hit)
    begin
      unique case (paddr[3:2])
        2'h0:
        begin
          rec_mem[ridx].mode <= astq_mode_t'(pwdata[17:16]);
          rec_mem[ridx].setpt <= pwdata[15:0];
        end
        2'h1:
        begin
          rec_mem[ridx].hi <= pwdata[31:16];
          rec_mem[ridx].lo <= pwdata[15:0];
        end
        2'h2:
        begin
          rec_mem[ridx].off_s <= pwdata[31:16];
          rec_mem[ridx].on_s <= pwdata[15:0];
        end
        2'h3: rec_mem[ridx].pf_s <= pwdata[15:0];
      endcase
    end
  end

  // Current program frame and step record.
  assign cur_p = prog_mem[prog_q - 4'h1];
  assign cur_ri = 7'({3'h0, prog_q} - 7'h01) * 7'h0a + {3'h0, step_q};
  assign cur_r = rec_mem[cur_ri];
  assign seek_r = find_sel(cur_p.active, first_q ? -1 : int'(step_q), 1'b1);
  assign back_r = find_sel(cur_p.active, int'(step_q), 1'b0);

  // Judge once: at the delay, or at the end of loading if the delay is longer.
  assign tick = (cyc_q == SCW'(SEC_CYC - 1)) && !paused_q;
  assign judge = state_q == S_LOAD && !sampled_q && !paused_q &&
                 (sec_q >= cur_r.pf_s || sec_q >= cur_r.on_s);
  assign bad = meas_value > cur_r.hi || meas_value < cur_r.lo;
  assign alert = (judge && bad) || (state_q == S_SEEK && seek_r[4] && !paused_q &&
                 (cur_p.chain == 4'h0 || cur_p.chain > 4'ha));

  // Phase timer in seconds; frozen while suspended.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cyc_q <= '0;
      sec_q <= 16'h0000;
    end
    else if (state_q == S_SEEK || state_q == S_STOP ||
             (state_q == S_LOAD && sec_q >= cur_r.on_s && !paused_q))
    begin
      cyc_q <= '0;
      sec_q <= 16'h0000;
    end
    else if (tick)
    begin
      cyc_q <= '0;
      sec_q <= sec_q + 16'h0001;
    end
    else if (!paused_q)
      cyc_q <= cyc_q + SCW'(1);
  end

  // Step sequencer.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= S_STOP;
      prog_q <= PROG_SEL_RST;
      step_q <= 4'h0;
      first_q <= 1'b1;
      paused_q <= 1'b0;
      sampled_q <= 1'b0;
      failed_q <= 1'b0;
      passed_q <= 1'b0;
    end
    else if (sw_stop_q)
    begin
      state_q <= S_STOP;
      paused_q <= 1'b0;
    end
    else if (state_q == S_STOP)
    begin
      prog_q <= prog_sel_q;
      if (cmd.start)
      begin
        state_q <= S_SEEK;
        first_q <= 1'b1;
        failed_q <= 1'b0;
        passed_q <= 1'b0;
        paused_q <= 1'b0;
      end
    end
    else
    begin
      // Pause suspends; start resumes.
      if (cmd.pause)
        paused_q <= 1'b1;
      else if (cmd.start)
        paused_q <= 1'b0;
      if (judge)
        sampled_q <= 1'b1;
      if (judge && bad)
        failed_q <= 1'b1;
      if (judge && bad && cur_p.stop_fail)
        state_q <= S_STOP;
      else if (cmd.next && !analog_q && state_q != S_SEEK)
      begin
        state_q <= S_SEEK;
        first_q <= 1'b0;
      end
      else if (cmd.prev && !analog_q)
      begin
        // Back to the previous selected step, or restart the first one.
        state_q <= S_LOAD;
        sampled_q <= 1'b0;
        if (!back_r[4])
          step_q <= back_r[3:0];
      end
      else if (!paused_q)
      begin
        unique case (state_q)
          S_SEEK:
          begin
            if (!seek_r[4])
            begin
              step_q <= seek_r[3:0];
              state_q <= S_LOAD;
              sampled_q <= 1'b0;
            end
            else if (cur_p.chain != 4'h0 && cur_p.chain <= 4'ha)
            begin
              prog_q <= cur_p.chain;
              first_q <= 1'b1;
            end
            else
            begin
              state_q <= S_STOP;
              passed_q <= !failed_q;
            end
          end
          S_LOAD:
            if (sec_q >= cur_r.on_s)
              state_q <= S_UNLOAD;
          S_UNLOAD:
            if (sec_q >= cur_r.off_s)
            begin
              state_q <= S_SEEK;
              first_q <= 1'b0;
              // A pause arriving on this same edge must not be lost.
              paused_q <= cur_p.hold[step_q] || cmd.pause;
            end
          default:
            state_q <= S_STOP;
        endcase
      end
    end
  end

  // Analog control: the step inputs pick the regulation mode instead.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      op_mode_q <= 2'h0;
    else if (analog_q && cmd.prev)
      op_mode_q <= 2'h1;
    else if (analog_q && cmd.next)
      op_mode_q <= 2'h2;
    else if (!analog_q)
      op_mode_q <= 2'h0;
  end

  // Tone burst on a failure or at the end of a run.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tone_q <= '0;
    else if (alert)
      tone_q <= TCW'(TONE_CYC);
    else if (tone_q != '0)
      tone_q <= tone_q - TCW'(1);
  end

  // Registered outputs toward the load and the connector.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      load_on <= 1'b0;
      short_on <= 1'b0;
      step_mode <= 2'h0;
      step_setpt <= 16'h0000;
      constant_current_op <= 1'b0;
      constant_voltage_op <= 1'b0;
      pin_input_on <= OUT_ACT_LOW;
      pin_fail <= OUT_ACT_LOW;
      pin_pass <= OUT_ACT_LOW;
      pin_tone <= OUT_ACT_LOW;
    end
    else
    begin
      load_on <= state_q == S_LOAD && !cur_p.shrt[step_q];
      short_on <= state_q == S_LOAD && cur_p.shrt[step_q];
      step_mode <= cur_r.mode;
      step_setpt <= cur_r.setpt;
      constant_current_op <= op_mode_q == 2'h1;
      constant_voltage_op <= op_mode_q == 2'h2;
      pin_input_on <= (state_q == S_LOAD) ^ OUT_ACT_LOW;
      pin_fail <= failed_q ^ OUT_ACT_LOW;
      pin_pass <= passed_q ^ OUT_ACT_LOW;
      pin_tone <= (tone_q != '0) ^ OUT_ACT_LOW;
    end
  end

endmodule

// file: astq_pkg.sv
// Package of constants and types shared by the auto test sequencer files.
package astq_pkg;

  // Storage geometry: programs, steps per program and step records.
  localparam int NUM_PROG = 10;
  localparam int NUM_STEP = 10;
  localparam int NUM_REC = 100;

  // Clock period and the one-second unit used by all step intervals.
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_UNIT_S = 1;
  localparam int SEC_CYCLES = STEP_UNIT_S * 1000000000 / CLK_PERIOD_NS;

  // Least width of a connector input pulse, rounded up to whole cycles.
  localparam int MIN_PULSE_NS = 1000;
  localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Length of one warning tone burst.
  localparam int TONE_MS = 100;
  localparam int TONE_CYCLES = TONE_MS * 1000000 / CLK_PERIOD_NS;

  // Connector polarity: inputs and outputs are active low by default.
  localparam bit IN_ACT_LOW_DEF = 1'b1;
  localparam bit OUT_ACT_LOW_DEF = 1'b1;

  // Register byte offsets.
  localparam logic [11:0] CTRL_OFF = 12'h000;
  localparam logic [11:0] STAT_OFF = 12'h004;
  localparam logic [11:0] PROG_BASE = 12'h100;
  localparam logic [11:0] PROG_END = 12'h150;
  localparam logic [11:0] REC_BASE = 12'h800;
  localparam logic [11:0] REC_END = 12'he40;

  // Control register fields.
  localparam int CTRL_START = 0;
  localparam int CTRL_PAUSE = 1;
  localparam int CTRL_NEXT = 2;
  localparam int CTRL_PREV = 3;
  localparam int CTRL_STOP = 4;
  localparam int CTRL_RECALL = 5;
  localparam int CTRL_ANALOG = 6;
  localparam int CTRL_PROG_LSB = 8;
  localparam logic [3:0] PROG_SEL_RST = 4'h1;

  // Sequencer states.
  typedef enum logic [1:0] {
    S_STOP = 2'h0,
    S_SEEK = 2'h1,
    S_LOAD = 2'h2,
    S_UNLOAD = 2'h3
  } astq_state_t;

  // Working mode of a step.
  typedef enum logic [1:0] {
    M_CC = 2'h0,
    M_CV = 2'h1,
    M_CR = 2'h2,
    M_CW = 2'h3
  } astq_mode_t;

  // Program frame: step masks, stop condition and chain target.
  typedef struct packed {
    logic [9:0] shrt;
    logic [9:0] hold;
    logic [9:0] active;
    logic stop_fail;
    logic [3:0] chain;
  } astq_prog_t;

  // One step record.
  typedef struct packed {
    astq_mode_t mode;
    logic [15:0] setpt;
    logic [15:0] hi;
    logic [15:0] lo;
    logic [15:0] on_s;
    logic [15:0] off_s;
    logic [15:0] pf_s;
  } astq_rec_t;

  // Commands seen from the connector or from software.
  typedef struct packed {
    logic start;
    logic pause;
    logic next;
    logic prev;
  } astq_cmd_t;

endpackage

// file: astq_pin_cond.sv
// Connector input conditioner: polarity and least pulse width qualification.
`timescale 1ns/1ps
module astq_pin_cond
  import astq_pkg::*;
#(
  parameter bit ACT_LOW = 1'b1,
  parameter int MIN_CYC = 100
)
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Raw pin level and qualified event.
  input wire logic pin,
  output logic fire
);

  localparam int CW = $clog2(MIN_CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(MIN_CYC - 1);

  // Refuse a width that cannot be counted.
  if (MIN_CYC < 1)
  begin : g_bad
    $error("Least pulse width must be at least one cycle.");
  end

  logic act; // Pin in its active level.
  logic [CW-1:0] cnt_q; // Cycles the pin has stood active.

  assign act = pin ^ ACT_LOW;

  // Count active cycles; a shorter glitch is no longer active when the count reaches the last count.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= '0;
    else if (!act)
      cnt_q <= '0;
    else if (cnt_q <= LAST)
      cnt_q <= cnt_q + CW'(1);
  end

  // One pulse per qualified assertion, however long it is then held.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      fire <= 1'b0;
    else
      fire <= act && (cnt_q == LAST);
  end

endmodule

// file: astq_chk.sv
// Port timing checker for the auto test sequencer, bound to its top.
`timescale 1ns/1ps
module astq_chk
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Bus handshake.
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Load side and connector outputs.
  input wire logic load_on,
  input wire logic short_on,
  input wire logic pin_input_on,
  input wire logic pin_fail,
  input wire logic pin_pass,
  input wire logic pin_tone,
  input wire logic constant_current_op,
  input wire logic constant_voltage_op
);
  // Every check uses the one clock and its reset.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // An access is answered after exactly one wait state.
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("Ready late.");
  // The answer lasts a single cycle.
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready too long.");
  // An error flag only comes with the answer.
  err_ready_a: assert property (pslverr |-> pready)
    else $error("Stray error.");
  // Normal and short loading never overlap.
  load_short_a:
    assert property (!(load_on && short_on)) else $error("Load and short.");
  // The input-on pin follows the loading phase.
  input_on_a:
    assert property ($rose(load_on || short_on) |-> ##[0:4] !pin_input_on)
    else $error("Input-on late.");
  // Pass and fail are never shown together.
  verdict_excl_a:
    assert property (pin_pass || pin_fail) else $error("Pass with fail.");
  // A tone burst lasts at least five cycles.
  tone_len_a:
    assert property ($fell(pin_tone) |-> !pin_tone [*5]) else $error("Tone short.");
  // A failure sounds the tone.
  fail_tone_a:
    assert property ($fell(pin_fail) |-> ##[0:4] !pin_tone) else $error("No tone.");
  // Only one analog mode is picked at a time.
  mode_excl_a:
    assert property (!(constant_current_op && constant_voltage_op))
    else $error("Two modes.");
  // Main scenarios reached.
  cover property ($rose(short_on));
  cover property ($fell(pin_pass));
  cover property ($fell(pin_fail));
endmodule

bind astq_top astq_chk i_astq_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .load_on, .short_on, .pin_input_on, .pin_fail, .pin_pass, .pin_tone,
  .constant_current_op, .constant_voltage_op);

// file: astq_fixture.sv
// Model of the external fixture that works the connector inputs.
`timescale 1ns/1ps
module astq_fixture
#(
  parameter int HOLD_CYC = 2
)
(
  // Clock.
  input wire logic pclk,
  // Connector inputs of the device, active low.
  output logic pin_start,
  output logic pin_pause,
  output logic pin_next_step,
  output logic pin_prev_step
);
  // Pin levels; all idle high until pressed.
  logic [3:0] lvl_q;
  assign {pin_prev_step, pin_next_step, pin_pause, pin_start} = lvl_q;
  initial lvl_q <= 4'hf;
  // Holds one pin low past the least width, then releases it before any other.
  task automatic press(input int k);
    @(posedge pclk);
    lvl_q[k] <= 1'b0;
    repeat (HOLD_CYC + 2) @(posedge pclk);
    lvl_q[k] <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask
endmodule

// file: astq_top_test.sv
// Self-checking bench of the auto test sequencer.
`timescale 1ns/1ps
module astq_top_test
  import astq_pkg::*;
;
  // One second in simulation cycles.
  localparam int SEC = 20;
  // Clock, reset and bus master signals.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready, pslverr;
  // Connector and load side.
  logic pin_prev_step, pin_start, pin_next_step, pin_pause;
  logic pin_input_on, pin_fail, pin_pass, pin_tone;
  logic [15:0] meas_value;
  logic load_on, short_on, constant_current_op, constant_voltage_op;
  logic [1:0] step_mode;
  logic [15:0] step_setpt;
  // Bookkeeping: counts, last read word and error flag, wait length.
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int n;
  logic [31:0] r;
  logic e;

  // Free-running clock.
  always #5 pclk = ~pclk;

  astq_top #(.SEC_CYC(SEC), .TONE_CYC(5), .PULSE_CYC(2)) i_astq_top (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pin_prev_step, .pin_start, .pin_next_step, .pin_pause, .pin_input_on, .pin_fail,
    .pin_pass, .pin_tone, .meas_value, .load_on, .short_on, .step_mode, .step_setpt,
    .constant_current_op, .constant_voltage_op);
  astq_fixture #(.HOLD_CYC(2)) i_astq_fixture (.pclk, .pin_start, .pin_pause,
    .pin_next_step, .pin_prev_step);

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d.", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Counts a comparison and reports a mismatch.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Checks the last wait length against a figure and a tolerance.
  task automatic near(input int x, input int tol);
    chk(32'(n >= x - tol && n <= x + tol), 32'h1);
  endtask

  // One bus transfer, held until pready is seen at a rising edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
      chk(32'h0, 32'h1);
  endtask

  // Waits for load, short, pass or fail to reach a level; n counts edges.
  task automatic wt(input int s, input logic lv);
    logic [3:0] v;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      v = {pin_fail, pin_pass, short_on, load_on};
    end
    while (v[s] !== lv && n < 400);
    if (n == 400)
      chk(32'h0, 32'h1);
  endtask

  // Writes a step record; limits 20..100, on 2 s, off 1 s, delay 1 s.
  task automatic rec(input int i, input logic [31:0] w0);
    logic [11:0] b;
    b = REC_BASE + 12'(16 * (i - 1));
    apb(1'b1, b, w0);
    apb(1'b1, b + 12'h4, 32'h0100_0020);
    apb(1'b1, b + 12'h8, 32'h0001_0002);
    apb(1'b1, b + 12'hc, 32'h0000_0001);
  endtask

  // Writes both words of a program frame.
  task automatic prog(input int p, input logic [31:0] w0, input logic [31:0] w1);
    apb(1'b1, PROG_BASE + 12'(8 * (p - 1)), w0);
    apb(1'b1, PROG_BASE + 12'(8 * (p - 1)) + 12'h4, w1);
  endtask

  // Presses a connector input in the background.
  task automatic go(input int k);
    fork
      i_astq_fixture.press(k);
    join_none
  endtask

  // Cuts a hang short.
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  // Main sequence.
  initial
  begin
    // Idle bus and a reading above the limits until the tests change them.
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    meas_value <= 16'h0300;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Storage map, the last record and the first unmapped word.
    rec(1, 32'h0000_0200);
    rec(2, 32'h0001_0300);
    rec(11, 32'h0002_0400);
    rec(100, 32'h0003_0500);
    apb(1'b0, 12'h8a0, 32'h0);
    chk(r & 32'h3ffff, 32'h0002_0400);
    apb(1'b0, 12'he3c, 32'h0);
    chk(r & 32'hffff, 32'h1);
    apb(1'b0, REC_END, 32'h0);
    chk(r, 32'h0000_0000);
    chk({31'h0000_0000, e}, 32'h0000_0001);
    $display("Test map done.");
    // Full run; the reading turns good only after ten cycles of loading.
    prog(1, 32'h0020_0003, 32'h0);
    go(0);
    wt(0, 1'b1);
    chk(step_setpt, 16'h0200);
    repeat (10) @(posedge pclk);
    meas_value <= 16'h0050;
    wt(0, 1'b0);
    near(2 * SEC - 10, 1);
    wt(1, 1'b1);
    near(SEC + 2, 2);
    chk(load_on, 1'b0);
    wt(1, 1'b0);
    near(2 * SEC, 1);
    wt(2, 1'b0);
    chk(pin_fail, 1'b1);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r & 32'h33, 32'h20);
    $display("Test run done.");
    // Bad reading with stop on failure.
    meas_value <= 16'h0300;
    prog(1, 32'h0020_0003, 32'h10);
    go(0);
    wt(3, 1'b0);
    chk({pin_pass, pin_tone, pin_input_on, load_on, short_on}, 5'b10100);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r & 32'hf013, 32'h10);
    $display("Test fail done.");
    // Pause freezes loading; a hold flag waits for start.
    meas_value <= 16'h0050;
    prog(1, 32'h0000_0403, 32'h0);
    go(0);
    wt(0, 1'b1);
    i_astq_fixture.press(1);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r[3], 1'b1);
    repeat (2 * SEC + 5) @(posedge pclk);
    chk(load_on, 1'b1);
    i_astq_fixture.press(0);
    wt(0, 1'b0);
    repeat (3 * SEC) @(posedge pclk);
    apb(1'b0, STAT_OFF, 32'h0);
    chk({r[3], load_on}, 2'b10);
    go(0);
    wt(0, 1'b1);
    chk(step_setpt, 16'h0300);
    wt(2, 1'b0);
    $display("Test hold done.");
    // Next and previous move one step; software stops the run.
    prog(1, 32'h0000_0003, 32'h0);
    go(0);
    wt(0, 1'b1);
    i_astq_fixture.press(2);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r[15:12], 4'h1);
    i_astq_fixture.press(3);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r[15:12], 4'h0);
    apb(1'b1, CTRL_OFF, 32'h10);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r[1:0], 2'h0);
    $display("Test step done.");
    // Skipped step, chain to program 2, then recall of program 3.
    prog(1, 32'h0000_0002, 32'h2);
    prog(2, 32'h0000_0001, 32'h0);
    go(0);
    wt(0, 1'b1);
    chk(step_setpt, 16'h0300);
    wt(0, 1'b0);
    wt(0, 1'b1);
    chk({step_mode, step_setpt}, 18'h2_0400);
    wt(2, 1'b0);
    apb(1'b1, CTRL_OFF, 32'h320);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r & 32'hf03, 32'h300);
    $display("Test chain done.");
    // Analog mode: previous picks current, next picks voltage.
    apb(1'b1, CTRL_OFF, 32'h40);
    i_astq_fixture.press(3);
    chk({constant_current_op, constant_voltage_op}, 2'b10);
    i_astq_fixture.press(2);
    chk({constant_current_op, constant_voltage_op}, 2'b01);
    apb(1'b0, STAT_OFF, 32'h0);
    chk(r[1:0], 2'h0);
    $display("Test analog done.");
    give_verdict();
  end
endmodule
